// *** src/mpmfv_top.sv ***
// Register file, PHY management, pause flow control and VLAN tag detection.
// Assumes Avalon-MM master on core_clk; frame path and PHY on the same clock.
`timescale 1ns/1ps
module mpmfv_top (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic phy_req,
    output logic phy_req_write,
    output logic [4:0] phy_req_addr,
    output logic [4:0] phy_req_index,
    output logic [15:0] phy_req_wdata,
    input wire logic phy_done,
    input wire logic [15:0] phy_rdata,
    input wire logic full_duplex,
    input wire logic promiscuous,
    input wire logic rx_frame_end,
    input wire logic rx_is_pause,
    input wire logic [15:0] rx_pause_quanta,
    input wire logic rx_byte_valid,
    input wire logic [10:0] rx_byte_count,
    input wire logic [7:0] rx_byte,
    input wire logic rx_over_pressure,
    input wire logic tx_pause_done,
    output logic tx_pause_send,
    output logic [15:0] tx_pause_time,
    output logic tx_hold_off,
    output logic rx_back_pressure,
    output logic rx_status_valid,
    output logic rx_status_filter,
    output logic rx_status_vlan,
    output logic rx_status_too_long,
    output logic rx_pause_seen,
    output logic [15:0] rx_coe_vlan_type
);
    import mpmfv_pkg::*;
    logic rd_done_r;
    logic [4:0] acc_phyaddr_r;
    logic [4:0] acc_index_r;
    logic acc_wnr_r;
    logic busy_r;
    logic [15:0] mdata_r;
    logic [15:0] ptime_r;
    logic pass_r;
    logic flow_ctrl_enable_r;
    logic flow_ctrl_busy_r;
    logic [15:0] vlan_r;
    logic seq_start_r;
    logic seq_finish;
    logic [15:0] seq_rdata;
    logic wr_acc;
    logic wr_data;
    logic wr_flow;
    logic wr_vlan;
    logic [7:0] tag_hi_r;
    logic tagged_r;
    logic [15:0] hold_quanta_r;
    logic [9:0] slot_cnt_r;
    logic pause_valid;
    logic rx_send_start;
    logic pressure_sync1_r;
    logic pressure_sync2_r;
    logic pressure_r;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // Writes complete on the request edge; reads answer one cycle later
    assign wr_acc = avs_write && avs_address == ADDR_PHY_ACCESS && avs_byteenable[0];
    assign wr_data = avs_write && avs_address == ADDR_PHY_DATA;
    assign wr_flow = avs_write && avs_address == ADDR_PAUSE_CTRL;
    assign wr_vlan = avs_write && avs_address == ADDR_VLAN_ONE;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_done_r <= 1'b0;
        end else begin
            rd_done_r <= avs_read && !rd_done_r;
        end
    end

    always_comb begin
        avs_waitrequest = avs_read && !rd_done_r;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !rd_done_r) begin
            case (avs_address)
                ADDR_PHY_ACCESS: begin
                    avs_readdata <= {16'h0000, acc_phyaddr_r, acc_index_r, 4'h0, acc_wnr_r, busy_r};
                end
                ADDR_PHY_DATA: begin
                    avs_readdata <= {16'h0000, mdata_r};
                end
                ADDR_PAUSE_CTRL: begin
                    avs_readdata <= {ptime_r, 13'h0000, pass_r, flow_ctrl_enable_r, flow_ctrl_busy_r};
                end
                ADDR_VLAN_ONE: begin
                    avs_readdata <= {16'h0000, vlan_r};
                end
                default: begin
                    avs_readdata <= UNMAPPED_READ;
                end
            endcase
        end
    end

    // ----------------------------------------
    // PHY management registers
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_phyaddr_r <= 5'h00;
            acc_index_r <= 5'h00;
            acc_wnr_r <= 1'b0;
            busy_r <= 1'b0;
            seq_start_r <= 1'b0;
        end else begin
            seq_start_r <= 1'b0;
            if (seq_finish) begin
                busy_r <= 1'b0;
            end else if (wr_acc && !busy_r) begin
                acc_phyaddr_r <= avs_writedata[PHYADDR_HI:PHYADDR_LO];
                acc_index_r <= avs_writedata[REGIDX_HI:REGIDX_LO];
                acc_wnr_r <= avs_writedata[WNR_BIT];
                busy_r <= avs_writedata[BUSY_BIT];
                seq_start_r <= avs_writedata[BUSY_BIT];
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mdata_r <= DATA_RESET;
        end else if (seq_finish && !acc_wnr_r) begin
            mdata_r <= seq_rdata;
        end else if (wr_data && !busy_r) begin
            if (avs_byteenable[0]) begin
                mdata_r[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                mdata_r[15:8] <= avs_writedata[15:8];
            end
        end
    end

    mpmfv_mgmt_seq u_seq (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .start(seq_start_r),
        .write_not_read(acc_wnr_r),
        .phy_addr(acc_phyaddr_r),
        .reg_index(acc_index_r),
        .wdata(mdata_r),
        .phy_done(phy_done),
        .phy_rdata(phy_rdata),
        .req_r(phy_req),
        .req_write_r(phy_req_write),
        .req_addr_r(phy_req_addr),
        .req_index_r(phy_req_index),
        .req_wdata_r(phy_req_wdata),
        .finish_r(seq_finish),
        .rdata_r(seq_rdata)
    );

    // ----------------------------------------
    // Flow control register
    // ----------------------------------------
    // A write of 1 to the busy bit requests one pause frame (or back pressure)
    assign rx_send_start = wr_flow && avs_writedata[FLOW_CTRL_BUSY_BIT] && !flow_ctrl_busy_r;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ptime_r <= PTIME_RESET;
            pass_r <= 1'b0;
            flow_ctrl_enable_r <= 1'b0;
        end else if (wr_flow) begin
            if (avs_byteenable[0]) begin
                pass_r <= avs_writedata[PASS_BIT];
                flow_ctrl_enable_r <= avs_writedata[FLOW_CTRL_ENABLE_BIT];
            end
            if (avs_byteenable[3] && avs_byteenable[2]) begin
                ptime_r <= avs_writedata[31:PTIME_LO];
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flow_ctrl_busy_r <= 1'b0;
            tx_pause_send <= 1'b0;
        end else if (flow_ctrl_busy_r) begin
            tx_pause_send <= 1'b0;
            if (full_duplex ? tx_pause_done : !pressure_r) begin
                flow_ctrl_busy_r <= 1'b0;
            end
        end else if (rx_send_start) begin
            flow_ctrl_busy_r <= 1'b1;
            tx_pause_send <= full_duplex;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_pause_time <= 16'h0000;
        end else begin
            tx_pause_time <= wr_flow && &avs_byteenable[3:2] ? avs_writedata[31:PTIME_LO] : ptime_r;
        end
    end

    // ----------------------------------------
    // Back pressure in half duplex
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pressure_sync1_r <= 1'b0;
            pressure_sync2_r <= 1'b0;
        end else begin
            pressure_sync1_r <= rx_over_pressure;
            pressure_sync2_r <= pressure_sync1_r;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pressure_r <= 1'b0;
            rx_back_pressure <= 1'b0;
        end else begin
            pressure_r <= flow_ctrl_enable_r && !full_duplex && (pressure_sync2_r || rx_send_start);
            rx_back_pressure <= pressure_r;
        end
    end

    // ----------------------------------------
    // Received pause handling
    // ----------------------------------------
    assign pause_valid = rx_frame_end && rx_is_pause && flow_ctrl_enable_r && full_duplex;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_quanta_r <= 16'h0000;
            slot_cnt_r <= 10'h000;
            tx_hold_off <= 1'b0;
        end else if (pause_valid) begin
            hold_quanta_r <= rx_pause_quanta;
            slot_cnt_r <= SLOT_CYCLES;
            tx_hold_off <= rx_pause_quanta != 16'h0000;
        end else if (hold_quanta_r != 16'h0000) begin
            if (slot_cnt_r == 10'h001) begin
                slot_cnt_r <= SLOT_CYCLES;
                hold_quanta_r <= hold_quanta_r - 16'h0001;
                tx_hold_off <= hold_quanta_r != 16'h0001;
            end else begin
                slot_cnt_r <= slot_cnt_r - 10'h001;
            end
        end else begin
            tx_hold_off <= 1'b0;
        end
    end

    // ----------------------------------------
    // VLAN tag detection and receive status
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vlan_r <= VLAN_RESET;
        end else if (wr_vlan) begin
            if (avs_byteenable[0]) begin
                vlan_r[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                vlan_r[15:8] <= avs_writedata[15:8];
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_coe_vlan_type <= VLAN_RESET;
        end else begin
            rx_coe_vlan_type <= vlan_r;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tag_hi_r <= 8'h00;
            tagged_r <= 1'b0;
        end else if (rx_frame_end) begin
            tagged_r <= 1'b0;
        end else if (rx_byte_valid) begin
            if (rx_byte_count == 11'd13) begin
                tag_hi_r <= rx_byte;
            end
            if (rx_byte_count == 11'd14) begin
                tagged_r <= {tag_hi_r, rx_byte} == vlan_r;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_status_valid <= 1'b0;
            rx_status_filter <= 1'b0;
            rx_status_vlan <= 1'b0;
            rx_status_too_long <= 1'b0;
            rx_pause_seen <= 1'b0;
        end else begin
            rx_status_valid <= rx_frame_end;
            rx_pause_seen <= pause_valid;
            if (rx_frame_end) begin
                rx_status_vlan <= tagged_r;
                rx_status_too_long <= rx_byte_count > (tagged_r ? MAX_LEN_VLAN : MAX_LEN_PLAIN);
                if (promiscuous) begin
                    rx_status_filter <= 1'b1;
                end else begin
                    rx_status_filter <= pass_r && rx_is_pause;
                end
            end
        end
    end
endmodule

// *** src/mpmfv_pkg.sv ***
// Constants for the PHY management, pause control and VLAN tag slice of the MAC.
// Assumes a 32-bit Avalon-MM register bus on a single 10 MHz clock.
// Summary of operation
// - Register index bits 10:6 select PHY register
// - Direction bit set writes, clear reads
// - Busy set by software, cleared when done
// - Read value loaded on the edge busy clears
// - Data register holds 16 bits, resets zero
// - Pause time field goes into pause frames
// - Pass-control sets packet-filter status bit
// - Pause obeyed only full-duplex and enabled
// - Every received frame passed with status
// - Filtering modes override pass-control setting
// - Enable decodes pause, holds transmitter off
// - Half duplex enable means back pressure
// - Flow busy high while pause or pressure
// - Tag value compared to bytes 13-14
// - Tagged frames allowed up to 1522 bytes
// - Checksum offload shares the tag value
package mpmfv_pkg;
    localparam logic [11:0] ADDR_PHY_ACCESS = 12'h114;
    localparam logic [11:0] ADDR_PHY_DATA = 12'h118;
    localparam logic [11:0] ADDR_PAUSE_CTRL = 12'h11C;
    localparam logic [11:0] ADDR_VLAN_ONE = 12'h120;
    localparam int PHYADDR_HI = 15;
    localparam int PHYADDR_LO = 11;
    localparam int REGIDX_HI = 10;
    localparam int REGIDX_LO = 6;
    localparam int WNR_BIT = 1;
    localparam int BUSY_BIT = 0;
    localparam int PASS_BIT = 2;
    localparam int FLOW_CTRL_ENABLE_BIT = 1;
    localparam int FLOW_CTRL_BUSY_BIT = 0;
    localparam int PTIME_LO = 16;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [15:0] VLAN_RESET = 16'hFFFF;
    localparam logic [15:0] PTIME_RESET = 16'h0000;
    localparam logic [10:0] MAX_LEN_PLAIN = 11'h5EE;
    localparam logic [10:0] MAX_LEN_VLAN = 11'h5F2;
    localparam int SLOT_BITS = 512;
    localparam logic [9:0] SLOT_CYCLES = 10'h200;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    typedef enum logic [2:0] {
        MPMFV_MI_IDLE = 3'b001,
        MPMFV_MI_RUN = 3'b010,
        MPMFV_MI_DONE = 3'b100
    } mpmfv_mi_state_type;
endpackage

// *** src/mpmfv_mgmt_seq.sv ***
// PHY management sequencer: one register access to the internal PHY per start.
// Assumes the PHY answers with a done pulse and read data valid with it.
`timescale 1ns/1ps
module mpmfv_mgmt_seq (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic write_not_read,
    input wire logic [4:0] phy_addr,
    input wire logic [4:0] reg_index,
    input wire logic [15:0] wdata,
    input wire logic phy_done,
    input wire logic [15:0] phy_rdata,
    output logic req_r,
    output logic req_write_r,
    output logic [4:0] req_addr_r,
    output logic [4:0] req_index_r,
    output logic [15:0] req_wdata_r,
    output logic finish_r,
    output logic [15:0] rdata_r
);
    import mpmfv_pkg::*;
    mpmfv_mi_state_type state_r;
    // ----------------------------------------
    // Access sequence
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= MPMFV_MI_IDLE;
            req_r <= 1'b0;
            req_write_r <= 1'b0;
            req_addr_r <= 5'h00;
            req_index_r <= 5'h00;
            req_wdata_r <= 16'h0000;
            finish_r <= 1'b0;
            rdata_r <= 16'h0000;
        end else begin
            finish_r <= 1'b0;
            case (state_r)
                MPMFV_MI_IDLE: begin
                    if (start) begin
                        req_r <= 1'b1;
                        req_write_r <= write_not_read;
                        req_addr_r <= phy_addr;
                        req_index_r <= reg_index;
                        req_wdata_r <= wdata;
                        state_r <= MPMFV_MI_RUN;
                    end
                end
                MPMFV_MI_RUN: begin
                    if (phy_done) begin
                        req_r <= 1'b0;
                        rdata_r <= phy_rdata;
                        state_r <= MPMFV_MI_DONE;
                    end
                end
                MPMFV_MI_DONE: begin
                    finish_r <= 1'b1;
                    state_r <= MPMFV_MI_IDLE;
                end
                default: begin
                    state_r <= MPMFV_MI_IDLE;
                end
            endcase
        end
    end
endmodule

// *** tb/mpmfv_phy_model.sv ***
// Behavioural internal PHY: 32 management words behind the request port.
// Assumes one request at a time; lat sets the answer delay in core_clk cycles.
`timescale 1ns/1ps
module mpmfv_phy_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic phy_req,
    input wire logic phy_req_write,
    input wire logic [4:0] phy_req_index,
    input wire logic [15:0] phy_req_wdata,
    input wire logic [7:0] lat,
    output logic phy_done,
    output logic [15:0] phy_rdata
);
    logic [15:0] regs [32];
    logic [7:0] cnt_r;
    // Read data only valid with the done pulse; it toggles otherwise
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 8'h00;
            phy_done <= 1'b0;
            phy_rdata <= 16'h5A5A;
            for (int i = 0; i < 32; i++) regs[i] <= 16'hA500 + 16'(i);
        end else begin
            phy_done <= 1'b0;
            phy_rdata <= ~phy_rdata;
            if (phy_req && !phy_done) begin
                cnt_r <= cnt_r + 8'h01;
                if (cnt_r >= lat) begin
                    cnt_r <= 8'h00;
                    phy_done <= 1'b1;
                    if (phy_req_write) regs[phy_req_index] <= phy_req_wdata;
                    else phy_rdata <= regs[phy_req_index];
                end
            end
        end
    end
endmodule

// *** tb/mpmfv_top_asserts.sv ***
// Concurrent checks on the ports of mpmfv_top.
// Assumes full-word register writes; bound to every mpmfv_top instance.
`timescale 1ns/1ps
module mpmfv_top_asserts (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [11:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic phy_req,
    input wire logic phy_req_write,
    input wire logic [4:0] phy_req_index,
    input wire logic [15:0] phy_req_wdata,
    input wire logic phy_done,
    input wire logic full_duplex,
    input wire logic promiscuous,
    input wire logic rx_frame_end,
    input wire logic rx_is_pause,
    input wire logic [15:0] rx_pause_quanta,
    input wire logic [10:0] rx_byte_count,
    input wire logic tx_pause_send,
    input wire logic [15:0] tx_pause_time,
    input wire logic tx_hold_off,
    input wire logic rx_status_valid,
    input wire logic rx_status_filter,
    input wire logic rx_status_vlan,
    input wire logic rx_status_too_long,
    input wire logic [15:0] rx_coe_vlan_type
);
    // ------------------------------
    // Shadow of the register writes
    // ------------------------------
    logic [1:0] idle_r;
    logic pend_r, wnr_r, flow_ctrl_enable_r, pass_r, wr_all, start_ok;
    logic [4:0] idx_r;
    logic [15:0] data_r, ptime_r, tag_r;
    assign wr_all = avs_write && avs_byteenable == 4'hF;
    assign start_ok = wr_all && avs_address == 12'h114 && avs_writedata[0] && idle_r == 2'h3;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {idle_r, pend_r, wnr_r, flow_ctrl_enable_r, pass_r, idx_r} <= {2'h3, 9'h000};
            {data_r, ptime_r, tag_r} <= {32'h0000_0000, 16'hFFFF};
        end else begin
            pend_r <= start_ok || (pend_r && !phy_req);
            if (start_ok || pend_r || phy_req) idle_r <= 2'h0;
            else if (idle_r != 2'h3) idle_r <= idle_r + 2'h1;
            if (start_ok) {idx_r, wnr_r} <= {avs_writedata[10:6], avs_writedata[1]};
            if (wr_all && avs_address == 12'h118 && idle_r == 2'h3) data_r <= avs_writedata[15:0];
            if (wr_all && avs_address == 12'h11C) {ptime_r, pass_r, flow_ctrl_enable_r} <= {avs_writedata[31:16], avs_writedata[2:1]};
            if (wr_all && avs_address == 12'h120) tag_r <= avs_writedata[15:0];
        end
    end
    // ------------------------------
    // Properties
    // ------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    phy_start_a: assert property (start_ok |-> ##[1:3] phy_req)
        else $error("phy request missing after start");
    phy_fields_a: assert property (phy_req |-> phy_req_index == idx_r && phy_req_write == wnr_r)
        else $error("phy request fields wrong");
    phy_wdata_a: assert property (phy_req && phy_req_write |-> phy_req_wdata == data_r)
        else $error("phy write data wrong");
    phy_hold_a: assert property (phy_req && !phy_done |=> phy_req)
        else $error("phy request dropped early");
    pause_time_a: assert property (tx_pause_send |-> tx_pause_time == ptime_r)
        else $error("pause time field wrong");
    pause_obey_a: assert property (rx_frame_end && rx_is_pause && flow_ctrl_enable_r && full_duplex
        && rx_pause_quanta != 16'h0000 |-> ##[1:3] tx_hold_off)
        else $error("pause frame not obeyed");
    pause_ignore_a: assert property (rx_frame_end && rx_is_pause && !(flow_ctrl_enable_r && full_duplex)
        && !tx_hold_off |=> !tx_hold_off [*4])
        else $error("pause frame obeyed while disabled");
    filter_bit_a: assert property (rx_status_valid && $past(rx_is_pause)
        |-> rx_status_filter == ($past(promiscuous) || pass_r))
        else $error("packet filter status wrong");
    frame_len_a: assert property (rx_status_valid
        |-> rx_status_too_long == ($past(rx_byte_count) > (rx_status_vlan ? 11'h5F2 : 11'h5EE)))
        else $error("frame length status wrong");
    coe_tag_a: assert property ($past(tag_r) == tag_r |-> rx_coe_vlan_type == tag_r)
        else $error("offload tag differs from register");
endmodule
bind mpmfv_top mpmfv_top_asserts chk (.core_clk, .sys_rst, .avs_address, .avs_write, .avs_writedata,
    .avs_byteenable, .phy_req, .phy_req_write, .phy_req_index, .phy_req_wdata, .phy_done, .full_duplex, .promiscuous,
    .rx_frame_end, .rx_is_pause, .rx_pause_quanta, .rx_byte_count, .tx_pause_send, .tx_pause_time, .tx_hold_off,
    .rx_status_valid, .rx_status_filter, .rx_status_vlan, .rx_status_too_long, .rx_coe_vlan_type);

// *** tb/tb.sv ***
// Self-checking bench for mpmfv_top with a behavioural PHY on its management port.
// Assumes a 100 ns core_clk and this module as the only Avalon-MM master.
`timescale 1ns/1ps
module tb;
    logic core_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, full_duplex = 1'b1;
    logic promiscuous = 1'b0, rx_frame_end = 1'b0, rx_is_pause = 1'b0, rx_byte_valid = 1'b0, tx_pause_done = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rv, hold;
    logic [3:0] avs_byteenable = 4'hF;
    logic [15:0] rx_pause_quanta = 16'h0, phy_rdata, phy_req_wdata, tx_pause_time, rx_coe_vlan_type, pt_seen;
    logic [10:0] rx_byte_count = 11'h000;
    logic [7:0] rx_byte = 8'h00, phy_lat = 8'h01;
    logic [4:0] phy_req_addr, phy_req_index, addr_seen;
    logic avs_waitrequest, phy_req, phy_req_write, phy_done, tx_pause_send, tx_hold_off, rx_back_pressure;
    logic rx_status_valid, rx_status_filter, rx_status_vlan, rx_status_too_long, rx_pause_seen, rx_over_pressure = 1'b0;
    int miscompares = 0, n_tests = 0, n_pause = 0;
    mpmfv_top dut (.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .phy_req, .phy_req_write, .phy_req_addr, .phy_req_index, .phy_req_wdata,
        .phy_done, .phy_rdata, .full_duplex, .promiscuous, .rx_frame_end, .rx_is_pause, .rx_pause_quanta,
        .rx_byte_valid, .rx_byte_count, .rx_byte, .rx_over_pressure, .tx_pause_done, .tx_pause_send,
        .tx_pause_time, .tx_hold_off, .rx_back_pressure, .rx_status_valid, .rx_status_filter, .rx_status_vlan,
        .rx_status_too_long, .rx_pause_seen, .rx_coe_vlan_type);
    mpmfv_phy_model phy (.core_clk, .sys_rst, .phy_req, .phy_req_write, .phy_req_index, .phy_req_wdata,
        .lat(phy_lat), .phy_done, .phy_rdata);
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) if (rx_pause_seen) n_pause++;
    always @(posedge core_clk) if (phy_req) addr_seen <= phy_req_addr;
    always @(posedge core_clk) if (tx_pause_send) pt_seen <= tx_pause_time;
    // ------------------------------
    // Bus, frame and compare tasks
    // ------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {avs_address, avs_writedata, avs_write} <= {a, d, 1'b1};
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        @(posedge core_clk);
        {avs_address, avs_read} <= {a, 1'b1};
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rv = avs_readdata;
        avs_read <= 1'b0;
        if (e !== 32'hFFFF_FFFF) chk(rv, e);
    endtask
    task automatic poll(input logic [11:0] a);
        rv = 32'h1;
        for (int i = 0; i < 400 && rv[0] !== 1'b0; i++) rd_chk(a, 32'hFFFF_FFFF);
        chk({31'h0, rv[0]}, 32'h0);
    endtask
    // e holds pause, expected filter, expected tag match, expected too long
    task automatic frame(input logic [15:0] ty, input logic [10:0] len, input logic [15:0] q, input logic [3:0] e);
        @(posedge core_clk);
        {rx_byte_valid, rx_byte_count, rx_byte} <= {1'b1, 11'h00D, ty[15:8]};
        @(posedge core_clk);
        {rx_byte_count, rx_byte} <= {11'h00E, ty[7:0]};
        @(posedge core_clk);
        {rx_byte_valid, rx_byte_count, rx_frame_end, rx_is_pause, rx_pause_quanta} <= {1'b0, len, 1'b1, e[3], q};
        @(posedge core_clk);
        {rx_frame_end, rx_is_pause} <= 2'b00;
        @(negedge core_clk);
        chk({29'h0, rx_status_valid, rx_status_vlan, rx_status_too_long}, {29'h0, 1'b1, e[1:0]});
        if (e[3]) chk({31'h0, rx_status_filter}, {31'h0, e[2]});
    endtask
    task automatic hold_chk(input logic [31:0] e);
        hold = 32'h0;
        repeat (800) begin
            if (tx_hold_off === 1'b1) hold++;
            @(negedge core_clk);
        end
        chk(hold, e);
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ------------------------------
    // Test sequence
    // ------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd_chk(12'h114, 32'h0);
        rd_chk(12'h118, 32'h0);
        rd_chk(12'h11C, 32'h0);
        rd_chk(12'h120, 32'h0000_FFFF);
        rd_chk(12'h130, 32'h0);
        chk({16'h0, rx_coe_vlan_type}, 32'h0000_FFFF);
        for (int k = 0; k < 2; k++) begin
            phy_lat <= (k == 0) ? 8'h01 : 8'h14;
            bus_wr(12'h118, 32'h1234 + k);
            bus_wr(12'h114, 32'h0803 | (k << 6));
            bus_wr(12'h118, 32'hDEAD);
            poll(12'h114);
            chk({16'h0, phy.regs[k]}, 32'h1234 + k);
            chk({27'h0, addr_seen}, 32'h1);
            rd_chk(12'h118, 32'h1234 + k);
            bus_wr(12'h114, 32'h0801 | ((k + 8) << 6));
            poll(12'h114);
            rd_chk(12'h118, 32'hA508 + k);
            rd_chk(12'h114, 32'h0800 | ((k + 8) << 6));
        end
        bus_wr(12'h11C, 32'h0003_0003);
        rd_chk(12'h11C, 32'h0003_0003);
        tx_pause_done <= 1'b1;
        @(posedge core_clk);
        tx_pause_done <= 1'b0;
        poll(12'h11C);
        chk({16'h0, pt_seen}, 32'h3);
        rd_chk(12'h11C, 32'h0003_0002);
        frame(16'h0800, 11'h040, 16'h0001, 4'h8);
        hold_chk(32'h200);
        bus_wr(12'h11C, 32'h4);
        frame(16'h0800, 11'h040, 16'h0000, 4'hC);
        bus_wr(12'h11C, 32'h0);
        frame(16'h0800, 11'h040, 16'h0001, 4'h8);
        hold_chk(32'h0);
        promiscuous <= 1'b1;
        frame(16'h0800, 11'h040, 16'h0000, 4'hC);
        promiscuous <= 1'b0;
        full_duplex <= 1'b0;
        bus_wr(12'h11C, 32'h2);
        frame(16'h0800, 11'h040, 16'h0001, 4'h8);
        hold_chk(32'h0);
        bus_wr(12'h120, 32'h8100);
        rd_chk(12'h120, 32'h8100);
        chk({16'h0, rx_coe_vlan_type}, 32'h8100);
        frame(16'h8100, 11'h5F2, 16'h0, 4'h2);
        frame(16'h8100, 11'h5F3, 16'h0, 4'h3);
        frame(16'h0800, 11'h5EE, 16'h0, 4'h0);
        frame(16'h0800, 11'h5EF, 16'h0, 4'h1);
        rx_over_pressure <= 1'b1;
        bus_wr(12'h11C, 32'h3);
        rd_chk(12'h11C, 32'h3);
        chk({31'h0, rx_back_pressure}, 32'h1);
        rx_over_pressure <= 1'b0;
        poll(12'h11C);
        chk(n_pause, 32'h1);
        close_out;
    end
    initial begin
        repeat (30000) @(posedge core_clk);
        miscompares++;
        close_out;
    end
endmodule
